// File: logic/sli_indicator.sv
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
// Summary of operation
// - non-fatal alarms blink status LED amber at about 1 Hz
// - excess correctable memory errors without redundancy also blink amber
// - fatal processor, thermal, power or memory faults light solid amber
// - processor mismatch or link frequency failure lights solid amber
// - boot sequence starts at power-on, restarts on update, cold reset, watchdog
// - video memory test failure: identify solid blue, status solid amber, held
// - both loader images bad: identify solid blue, status solid amber, held
// - loader stage: identify blinks blue 3 Hz, status blinks green 1 Hz
// - handed over: identify solid blue, status solid green
// - boot done: identify off, status follows conditions
// - latest progress code held on eight diagnostic LEDs
// - healthy running system shows solid green
// - degraded but functional blinks green at about 1 Hz
module sli_indicator
	import sli_pkg::*;
#(
	parameter int SLOW_HALF = SLOW_HALF_CYC,
	parameter int FAST_HALF = FAST_HALF_CYC
)
(
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	input  wire sli_alarm_t  alarm_in,
	input  wire sli_fatal_t  fatal_in,
	input  wire sli_degr_t   degr_in,
	input  wire logic        system_running,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             led_green,
	output logic             led_amber,
	output logic             led_identify,
	output logic [7:0]       post_led,
	output logic             irq
);

	// ==========================================================
	// pin synchronisers for condition inputs
	localparam int NIN = $bits(sli_alarm_t) + $bits(sli_fatal_t) + $bits(sli_degr_t) + 1;
	logic [NIN-1:0] in_meta_reg;
	logic [NIN-1:0] in_sync_reg;
	always_ff @(posedge mclk)
		if (!resetn)
		begin
			in_meta_reg <= '0;
			in_sync_reg <= '0;
		end
		else if (clk_en)
		begin
			in_meta_reg <= {alarm_in, fatal_in, degr_in, system_running};
			in_sync_reg <= in_meta_reg;
		end

	sli_alarm_t al;
	sli_fatal_t ft;
	sli_degr_t  dg;
	wire        run_s;
	assign {al, ft, dg, run_s} = in_sync_reg;

	// ==========================================================
	// blink timebases
	sli_boot_state_t state_reg;
	sli_boot_state_t state_next;
	// restart the phases on entry to the loader stage so its first blink is full length
	wire         enter_loader = (state_reg != BOOT_LOADER) && (state_next == BOOT_LOADER);
	logic [31:0] slow_cnt_reg;
	logic [31:0] fast_cnt_reg;
	logic        slow_ph_reg;
	logic        fast_ph_reg;
	wire         slow_wrap = (slow_cnt_reg == 32'(SLOW_HALF - 1));
	wire         fast_wrap = (fast_cnt_reg == 32'(FAST_HALF - 1));
	always_ff @(posedge mclk)
		if (!resetn || (clk_en && enter_loader))
		begin
			slow_cnt_reg <= '0;
			fast_cnt_reg <= '0;
			slow_ph_reg  <= 1'b0;
			fast_ph_reg  <= 1'b0;
		end
		else if (clk_en)
		begin
			slow_cnt_reg <= slow_wrap ? '0 : slow_cnt_reg + 32'h1;
			fast_cnt_reg <= fast_wrap ? '0 : fast_cnt_reg + 32'h1;
			slow_ph_reg  <= slow_wrap ? ~slow_ph_reg : slow_ph_reg;
			fast_ph_reg  <= fast_wrap ? ~fast_ph_reg : fast_ph_reg;
		end

	// ==========================================================
	// severity classification
	wire mem_alarm = !al.mem_redundant_mode & (al.mem_ce_window | al.mem_ce_failing_dimm);
	wire any_alarm = al.volt_crit | al.temp_crit | al.input_power_crit | al.rail_current_crit
		| al.regulator_hot_in | al.processor_hot_throttle | al.fans_insufficient
		| al.drive_fault | al.psu_insufficient | mem_alarm;
	wire any_fatal = ft.catastrophic_error_in | ft.processor_identity_mismatch | ft.cpu1_absent
		| ft.thermal_trip | ft.power_fault | ft.cpu_fatal_error_line
		| ft.mem_uncorrectable
		| ft.proc_family_mismatch | ft.proc_core_mismatch | ft.proc_cache_mismatch
		| ft.link_freq_fail;
	wire any_degr  = dg.redundancy_lost | dg.noncrit_threshold;
	sli_sev_t sev;
	assign sev = any_fatal ? SEV_FATAL : any_alarm ? SEV_ALARM
		: any_degr ? SEV_DEGR : SEV_OK;

	// ==========================================================
	// bus decode
	logic        aw_got_reg;
	logic        w_got_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	wire         aw_take  = s_axi_awvalid & s_axi_awready;
	wire         w_take   = s_axi_wvalid & s_axi_wready;
	wire         have_aw  = aw_got_reg | aw_take;
	wire         have_w   = w_got_reg | w_take;
	wire [7:0]   wr_addr  = aw_got_reg ? aw_addr_reg : s_axi_awaddr;
	wire [31:0]  wr_data  = w_got_reg ? w_data_reg : s_axi_wdata;
	wire [3:0]   wr_strb  = w_got_reg ? w_strb_reg : s_axi_wstrb;
	wire         wr_fire  = have_aw & have_w & !s_axi_bvalid;
	wire         wr_boot  = wr_fire & (wr_addr == ADDR_BOOT) & wr_strb[0];
	wire         wr_post  = wr_fire & (wr_addr == ADDR_POST) & wr_strb[0];
	wire         wr_en    = wr_fire & (wr_addr == ADDR_INT_EN) & wr_strb[0];
	wire         wr_clr   = wr_fire & (wr_addr == ADDR_INT_CLR) & wr_strb[0];
	wire         wr_ok    = (wr_addr == ADDR_CTRL) | (wr_addr == ADDR_BOOT)
		| (wr_addr == ADDR_POST) | (wr_addr == ADDR_INT_EN) | (wr_addr == ADDR_INT_CLR);
	wire         restart  = wr_fire & (wr_addr == ADDR_CTRL) & wr_strb[0] & wr_data[0];
	wire         aw_hold  = have_aw & !wr_fire;
	wire         w_hold   = have_w & !wr_fire;
	wire         b_next   = wr_fire | (s_axi_bvalid & !s_axi_bready);

	always_ff @(posedge mclk)
		if (!resetn)
		begin
			aw_got_reg    <= 1'b0;
			w_got_reg     <= 1'b0;
			aw_addr_reg   <= '0;
			w_data_reg    <= '0;
			w_strb_reg    <= '0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end
		else if (clk_en)
		begin
			if (aw_take)
				aw_addr_reg <= s_axi_awaddr;
			if (w_take)
			begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			aw_got_reg    <= aw_hold;
			w_got_reg     <= w_hold;
			s_axi_awready <= !aw_hold & !b_next;
			s_axi_wready  <= !w_hold & !b_next;
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end

	// ==========================================================
	// boot sequence of the management controller
	wire boot_fail = wr_boot & (wr_data[BOOT_VIDEO_FAIL_BIT] | wr_data[BOOT_IMAGES_BAD_BIT]);
	wire boot_rst  = restart | (wr_boot & wr_data[BOOT_RESTART_BIT]);
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			BOOT_IDLE:   state_next = BOOT_LOADER;
			BOOT_FAILED: state_next = BOOT_FAILED;
			BOOT_LOADER:
				if (boot_fail)
					state_next = BOOT_FAILED;
				else if (wr_boot & wr_data[BOOT_HANDOFF_BIT])
					state_next = BOOT_OS;
			BOOT_OS:
				if (boot_fail)
					state_next = BOOT_FAILED;
				else if (boot_rst)
					state_next = BOOT_LOADER;
				else if (wr_boot & wr_data[BOOT_DONE_BIT])
					state_next = BOOT_NORMAL;
			BOOT_NORMAL:
				if (boot_fail)
					state_next = BOOT_FAILED;
				else if (boot_rst)
					state_next = BOOT_LOADER;
			default: state_next = BOOT_FAILED;
		endcase
	end

	// ==========================================================
	// LED drivers
	logic green_next;
	logic amber_next;
	logic id_next;
	always_comb
	begin
		green_next = 1'b0;
		amber_next = 1'b0;
		id_next    = 1'b0;
		unique case (state_reg)
			BOOT_IDLE: ;
			BOOT_FAILED:
			begin
				id_next    = 1'b1;
				amber_next = 1'b1;
			end
			BOOT_LOADER:
			begin
				id_next    = fast_ph_reg;
				green_next = slow_ph_reg;
			end
			BOOT_OS:
			begin
				id_next    = 1'b1;
				green_next = 1'b1;
			end
			BOOT_NORMAL:
				unique case (sev)
					SEV_FATAL: amber_next = 1'b1;
					SEV_ALARM: amber_next = slow_ph_reg;
					SEV_DEGR:  green_next = slow_ph_reg;
					SEV_OK:    green_next = run_s;
				endcase
			default: ;
		endcase
	end

	// ==========================================================
	// interrupts and LED registers
	logic [3:0] int_stat_reg;
	logic [3:0] int_en_reg;
	logic       fatal_d_reg;
	logic       alarm_d_reg;
	wire [3:0]  int_set = {state_reg != BOOT_NORMAL && state_next == BOOT_NORMAL, wr_post,
		any_alarm & !alarm_d_reg, any_fatal & !fatal_d_reg};
	wire [3:0]  int_clr = wr_clr ? wr_data[3:0] : 4'h0;

	always_ff @(posedge mclk)
		if (!resetn)
		begin
			state_reg    <= BOOT_IDLE;
			led_green    <= 1'b0;
			led_amber    <= 1'b0;
			led_identify <= 1'b0;
			post_led     <= POST_RESET;
			int_stat_reg <= '0;
			int_en_reg   <= INT_EN_RESET;
			fatal_d_reg  <= 1'b0;
			alarm_d_reg  <= 1'b0;
			irq          <= 1'b0;
		end
		else if (clk_en)
		begin
			state_reg    <= state_next;
			led_green    <= green_next;
			led_amber    <= amber_next;
			led_identify <= id_next;
			if (wr_post)
				post_led <= wr_data[7:0];
			int_stat_reg <= (int_stat_reg & ~int_clr) | int_set;
			if (wr_en)
				int_en_reg <= wr_data[3:0];
			fatal_d_reg  <= any_fatal;
			alarm_d_reg  <= any_alarm;
			irq          <= |(((int_stat_reg & ~int_clr) | int_set) & int_en_reg);
		end

	// ==========================================================
	// read channel
	logic [31:0] rd_mux;
	always_comb
	begin
		unique case (s_axi_araddr)
			ADDR_CTRL:     rd_mux = 32'h0;
			ADDR_BOOT:     rd_mux = {27'h0, state_reg};
			ADDR_POST:     rd_mux = {24'h0, post_led};
			ADDR_STATUS:   rd_mux = {26'h0, led_identify, led_amber, led_green, 1'b0, sev};
			ADDR_INT_STAT: rd_mux = {28'h0, int_stat_reg};
			ADDR_INT_EN:   rd_mux = {28'h0, int_en_reg};
			ADDR_INT_CLR:  rd_mux = 32'h0;
			default:       rd_mux = 32'h0;
		endcase
	end
	wire rd_ok = (s_axi_araddr <= ADDR_INT_CLR) & (s_axi_araddr[1:0] == 2'h0);
	wire r_next = (s_axi_arvalid & s_axi_arready) | (s_axi_rvalid & !s_axi_rready);

	always_ff @(posedge mclk)
		if (!resetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= 2'h0;
			s_axi_arready <= 1'b0;
		end
		else if (clk_en)
		begin
			s_axi_arready <= !r_next;
			if (s_axi_arvalid & s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end

endmodule : sli_indicator

// File: logic/sli_pkg.sv
package sli_pkg;

	// ==========================================================
	// timing
	localparam int CLK_HZ            = 40000000;
	localparam int BLINK_SLOW_MHZ    = 1000;      // ~1 Hz, in millihertz
	localparam int BLINK_FAST_MHZ    = 3000;      // 3 Hz, in millihertz
	// half period in cycles: toggle twice per period
	localparam int SLOW_HALF_CYC     = (CLK_HZ / 2) / (BLINK_SLOW_MHZ / 1000);
	localparam int FAST_HALF_CYC     = (CLK_HZ / 2) / (BLINK_FAST_MHZ / 1000);

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_BOOT      = 8'h04;
	localparam logic [7:0] ADDR_POST      = 8'h08;
	localparam logic [7:0] ADDR_STATUS    = 8'h0c;
	localparam logic [7:0] ADDR_INT_STAT  = 8'h10;
	localparam logic [7:0] ADDR_INT_EN    = 8'h14;
	localparam logic [7:0] ADDR_INT_CLR   = 8'h18;

	// boot register fields
	localparam int BOOT_VIDEO_FAIL_BIT = 0;
	localparam int BOOT_IMAGES_BAD_BIT = 1;
	localparam int BOOT_HANDOFF_BIT    = 2;
	localparam int BOOT_DONE_BIT       = 3;
	localparam int BOOT_RESTART_BIT    = 4;

	// ctrl register: bit 0 force restart of the boot sequence from the OS or normal stage, as a pulse
	localparam logic [7:0]  POST_RESET    = 8'h00;
	localparam logic [3:0]  INT_EN_RESET  = 4'h0;

	// interrupt status bits
	localparam int IRQ_FATAL_BIT   = 0;
	localparam int IRQ_ALARM_BIT   = 1;
	localparam int IRQ_POST_BIT    = 2;
	localparam int IRQ_BOOTEND_BIT = 3;

	// ==========================================================
	// types
	typedef enum logic [4:0]
	{
		BOOT_LOADER = 5'b00001,
		BOOT_OS     = 5'b00010,
		BOOT_NORMAL = 5'b00100,
		BOOT_FAILED = 5'b01000,
		BOOT_IDLE   = 5'b10000
	} sli_boot_state_t;

	typedef enum logic [1:0]
	{
		SEV_OK    = 2'h0,
		SEV_DEGR  = 2'h1,
		SEV_ALARM = 2'h2,
		SEV_FATAL = 2'h3
	} sli_sev_t;

	typedef struct packed
	{
		logic volt_crit;
		logic temp_crit;
		logic input_power_crit;
		logic rail_current_crit;
		logic regulator_hot_in;
		logic processor_hot_throttle;
		logic fans_insufficient;
		logic drive_fault;
		logic psu_insufficient;
		logic mem_ce_window;
		logic mem_ce_failing_dimm;
		logic mem_redundant_mode;
	} sli_alarm_t;

	typedef struct packed
	{
		logic catastrophic_error_in;
		logic processor_identity_mismatch;
		logic cpu1_absent;
		logic thermal_trip;
		logic power_fault;
		logic cpu_fatal_error_line;
		logic mem_uncorrectable;
		logic proc_family_mismatch;
		logic proc_core_mismatch;
		logic proc_cache_mismatch;
		logic link_freq_fail;
	} sli_fatal_t;

	typedef struct packed
	{
		logic redundancy_lost;
		logic noncrit_threshold;
	} sli_degr_t;

endpackage : sli_pkg

// File: tb/sli_chk.sv
`timescale 1ns/10ps
module sli_chk
(
	input wire logic       mclk,
	input wire logic       resetn,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic       led_green,
	input wire logic       led_amber,
	input wire logic       led_identify,
	input wire logic [7:0] post_led,
	input wire logic       irq
);
	// ==========================================================
	// bus handshakes and lamp relations
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer withdrawn");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read answer withdrawn");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_reset_dark: assert property (disable iff (1'b0)
		!resetn |=> !led_green && !led_amber && !led_identify && post_led == 8'h00 && !irq)
		else $error("outputs not cleared by reset");
	a_lamp_exclusive: assert property (!(led_green && led_amber))
		else $error("green and amber lit together");
	a_ident_blink: assert property ($rose(led_identify) |=> led_identify [*2])
		else $error("identify high too short");
	a_post_hold: assert property (!$stable(post_led) |->
		s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
		else $error("progress code changed without a write");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_amber: cover property ($rose(led_amber));
	c_irq: cover property ($rose(irq));
endmodule : sli_chk

bind sli_indicator sli_chk u_chk (.mclk(mclk), .resetn(resetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.led_green(led_green), .led_amber(led_amber), .led_identify(led_identify),
	.post_led(post_led), .irq(irq));

// File: tb/sli_src.sv
`timescale 1ns/10ps
module sli_src
	import sli_pkg::*;
(
	output sli_alarm_t alarm_in,
	output sli_fatal_t fatal_in,
	output sli_degr_t  degr_in,
	output logic       system_running,
	input  wire logic  mclk
);
	// ==========================================================
	// condition levels, changed only just after a clock edge
	initial
	begin
		alarm_in = '0;
		fatal_in = '0;
		degr_in = '0;
		system_running = 1'b0;
	end
	task put(input sli_alarm_t a, input sli_fatal_t f, input sli_degr_t d, input logic r);
		@(posedge mclk);
		alarm_in <= a;
		fatal_in <= f;
		degr_in <= d;
		system_running <= r;
	endtask : put
endmodule : sli_src

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
	import sli_pkg::*;
;
	logic        mclk;
	logic        resetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, post_led;
	logic [31:0] wdata = 32'h0, rdata, h, d;
	logic [1:0]  bresp, rresp;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, green, amber, ident, irq, run;
	sli_alarm_t  alarm;
	sli_fatal_t  fatal;
	sli_degr_t   degr;
	int          bad_count = 0, checks = 0, i, exp_stat;
	logic [7:0]  post_q[$];

	sli_src src (.mclk(mclk), .alarm_in(alarm), .fatal_in(fatal), .degr_in(degr),
		.system_running(run));
	// short blink halves keep the run brief: 16-cycle slow period, 6-cycle fast period
	sli_indicator #(.SLOW_HALF(8), .FAST_HALF(3)) dut (.mclk(mclk), .resetn(resetn),
		.clk_en(1'b1), .alarm_in(alarm), .fatal_in(fatal), .degr_in(degr), .system_running(run),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.led_green(green), .led_amber(amber), .led_identify(ident), .post_led(post_led),
		.irq(irq));

	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// ==========================================================
	// shared tasks
	task wrap_up;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task lim(input int n);
		if (n == 40)
		begin
			bad_count++;
			wrap_up();
		end
	endtask : lim

	task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int n;
		@(posedge mclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge mclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		bready <= 1'b0;
		lim(n);
		chk({30'h0, bresp}, {30'h0, er});
	endtask : wr

	task rd(input logic [7:0] a, input logic [1:0] er);
		int n;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge mclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		d = rdata;
		rready <= 1'b0;
		lim(n);
		chk({30'h0, rresp}, {30'h0, er});
	endtask : rd

	task rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a, 2'h0);
		chk(d, e);
	endtask : rdc

	// lamps settle for a few cycles, then highs are counted over n cycles
	task hi(input int sel, input int n);
		repeat (8) @(posedge mclk);
		h = 0;
		repeat (n)
		begin
			@(posedge mclk);
			h = h + ((sel == 0) ? green : (sel == 1) ? amber : ident);
		end
	endtask : hi

	// ==========================================================
	// main sequence
	initial
	begin
		void'($urandom(93381));
		src.put('0, '0, '0, 1'b1);
		repeat (9) @(posedge mclk);
		resetn <= 1'b1;
		rdc(ADDR_BOOT, 32'h01);
		rdc(ADDR_POST, 32'(POST_RESET));
		rdc(ADDR_INT_EN, 32'(INT_EN_RESET));
		hi(2, 6);
		chk(h, 3);
		hi(0, 16);
		chk(h, 8);
		wr(ADDR_BOOT, 32'h1 << BOOT_RESTART_BIT, 2'h0);
		rdc(ADDR_BOOT, 32'h01);
		wr(ADDR_BOOT, 32'h1 << BOOT_HANDOFF_BIT, 2'h0);
		rdc(ADDR_BOOT, 32'h02);
		hi(2, 16);
		chk(h, 16);
		wr(ADDR_CTRL, 32'h1, 2'h0);
		rdc(ADDR_BOOT, 32'h01);
		wr(ADDR_BOOT, 32'h1 << BOOT_HANDOFF_BIT, 2'h0);
		wr(ADDR_BOOT, 32'h1 << BOOT_DONE_BIT, 2'h0);
		exp_stat = 8;
		rdc(ADDR_BOOT, 32'h04);
		hi(2, 16);
		chk(h, 0);
		hi(0, 16);
		chk(h, 16);
		d = 32'($urandom) & 32'hff;
		post_q.push_back(d[7:0]);
		wr(ADDR_POST, d, 2'h0);
		exp_stat = exp_stat | 4;
		rdc(ADDR_POST, {24'h0, post_q[$]});
		chk({24'h0, post_led}, {24'h0, post_q[$]});
		rdc(ADDR_INT_STAT, exp_stat);
		wr(ADDR_INT_EN, 32'h4, 2'h0);
		repeat (3) @(posedge mclk);
		chk(irq, 1);
		wr(ADDR_INT_CLR, 32'h4, 2'h0);
		exp_stat = 8;
		repeat (3) @(posedge mclk);
		chk(irq, 0);
		rdc(ADDR_INT_STAT, exp_stat);
		wr(8'h1c, 32'h5a, 2'h2);
		rd(8'h1c, 2'h2);
		chk(d, 0);
		src.put('0, '0, '0, 1'b0);
		hi(0, 16);
		chk(h, 0);
		src.put('0, '0, 2'b01, 1'b1);
		hi(0, 16);
		chk(h, 8);
		for (i = 3; i < 12; i++)
		begin
			src.put(sli_alarm_t'(12'h1 << i), '0, 2'b01, 1'b1);
			hi(1, 16);
			chk(h, 8);
		end
		src.put(12'h005, '0, '0, 1'b1);
		hi(1, 16);
		chk(h, 0);
		for (i = 1; i < 3; i++)
		begin
			src.put(sli_alarm_t'(12'h1 << i), '0, '0, 1'b1);
			hi(1, 16);
			chk(h, 8);
		end
		for (i = 0; i < 11; i++)
		begin
			src.put(sli_alarm_t'(12'($urandom)), sli_fatal_t'(11'h1 << i), 2'($urandom), 1'b1);
			hi(1, 16);
			chk(h, 16);
			rd(ADDR_STATUS, 2'h0);
			chk(d & 32'h3, 32'h3);
		end
		src.put('0, '0, '0, 1'b1);
		exp_stat = exp_stat | 3;
		rdc(ADDR_INT_STAT, exp_stat);
		wr(ADDR_BOOT, 32'h1 << BOOT_VIDEO_FAIL_BIT, 2'h0);
		hi(2, 16);
		chk(h, 16);
		hi(1, 16);
		chk(h, 16);
		wr(ADDR_BOOT, 32'h1 << BOOT_RESTART_BIT, 2'h0);
		rdc(ADDR_BOOT, 32'h08);
		resetn <= 1'b0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		wr(ADDR_BOOT, 32'h1 << BOOT_IMAGES_BAD_BIT, 2'h0);
		rdc(ADDR_BOOT, 32'h08);
		hi(1, 16);
		chk(h, 16);
		wrap_up();
	end
endmodule : tb_top
